/* File: hw/synth_pkg.sv */
// Constants, types and carriers shared by the synthesizer sequencer files
//
// Notes on behaviour
// - Frequency write with fast-lock enabled enters fast-lock once calibration ends.
// - During fast-lock the pump runs at the boost current field.
// - Timer expiry ends fast-lock; pump returns to the normal current field.
// - Fast-lock terminal count is 511 plus 512 times the timer field.
// - Calibration starts on frequency write only if mode bit 1 low, power-down high.
// - During calibration tuning ties to reference and the pump output is off.
// - Calibration lasts (6 + 2^P) x 8 + 3 clock periods.
// - Core select comes from frequency word; calibration picks band each frequency set.
// - Register contents are undefined at power-up; host writes every address.
// - Fast-lock enable is bit 11 of the function register, 1 enables.
// - Fast-lock timer field is bits 10 to 7 of the function register.
// - Normal pump current at bits 18 to 16, boost at 14 to 12.
package synth_pkg;

  // Register map
  localparam int          DATA_W     = 20;
  localparam int          ADDR_W     = 3;
  localparam int          NUM_REGS   = 4;
  localparam logic [2:0]  ADDR_FREQ1 = 3'h1;
  localparam logic [2:0]  ADDR_FREQ2 = 3'h2;
  localparam logic [2:0]  ADDR_FREQ3 = 3'h3;
  localparam logic [2:0]  ADDR_FUNC  = 3'h4;

  // Field positions
  localparam int FAST_EN_BIT    = 11;
  localparam int FAST_TMR_LSB   = 7;
  localparam int FAST_TMR_W     = 4;
  localparam int MODE_EXT_BIT   = 3;
  localparam int CAL_PREC_LSB   = 16;
  localparam int CAL_PREC_W     = 4;
  localparam int PUMP_NORM_LSB  = 16;
  localparam int PUMP_BOOST_LSB = 12;
  localparam int PUMP_W         = 3;
  localparam int VCO_SEL_LSB    = 16;
  localparam int VCO_SEL_W      = 2;

  // Reset values
  localparam logic [DATA_W-1:0] RDATA_RST = 20'h00000;

  // Timing counts in clock cycles
  localparam int FAST_BASE = 511;
  localparam int FAST_STEP = 512;
  localparam int CAL_BASE  = 6;
  localparam int CAL_MULT  = 8;
  localparam int CAL_TAIL  = 3;
  localparam int CAL_CNT_W = 19;
  localparam int FAST_CNT_W = 13;

  // Host-side timing, kept for reference by the host model
  localparam int CLK_MHZ         = 125;
  localparam int BIAS_SETTLE_US  = 500;
  localparam int REG_SETTLE_MS   = 10;
  localparam int BIAS_SETTLE_CYC = BIAS_SETTLE_US * CLK_MHZ;
  localparam int REG_SETTLE_CYC  = REG_SETTLE_MS * 1000 * CLK_MHZ;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_CAL  = 2'b01,
    ST_FAST = 2'b10,
    ST_NORM = 2'b11
  } seq_e;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } busReq_s;

  typedef struct packed {
    logic              enable;
    logic              tuneToRef;
    logic [PUMP_W-1:0] current;
  } pump_s;

endpackage

/* File: hw/reg_bank.sv */
// Small register store with registered read port and full word view
`timescale 1ns/1ps
`default_nettype none
module reg_bank #(
  parameter int W = 20,
  parameter int N = 4
) (
  input  wire logic                 mclk,
  input  wire logic                 rstn,
  input  wire logic                 wrEn,
  input  wire logic [$clog2(N)-1:0] wrIdx,
  input  wire logic [W-1:0]         wrData,
  input  wire logic                 rdEn,
  input  wire logic                 rdHit,
  input  wire logic [$clog2(N)-1:0] rdIdx,
  output logic      [W-1:0]         rdData,
  output logic      [N*W-1:0]       words
);

  // Elaboration check: at least two words of at least one bit
  if (W < 1 || N < 2) begin : gBadSize
    $error("reg_bank: bad size");
  end

  logic [W-1:0] mem [N];

  // Storage has no reset: contents stay undefined until written
  always_ff @(posedge mclk) begin
    if (wrEn) begin
      mem[wrIdx] <= wrData;
    end
  end

  // Read data valid in the cycle after the strobe only; misses read zero
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdData <= '0;
    end else if (rdEn && rdHit) begin
      rdData <= mem[rdIdx];
    end else begin
      rdData <= '0;
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gWord
      assign words[g*W +: W] = mem[g];
    end
  endgenerate

endmodule
`default_nettype wire

/* File: hw/synth_fastlock_vco_cal_sequencer.sv */
// Calibration and fast-lock sequencer with its register port
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module synth_fastlock_vco_cal_sequencer #(
  parameter int FL_BASE  = synth_pkg::FAST_BASE,
  parameter int FL_STEP  = synth_pkg::FAST_STEP,
  parameter int CL_BASE  = synth_pkg::CAL_BASE,
  parameter int CL_MULT  = synth_pkg::CAL_MULT,
  parameter int CL_TAIL  = synth_pkg::CAL_TAIL
) (
  input  wire logic                                mclk,
  input  wire logic                                rstn,
  input  wire logic                                powerDownN,
  input  wire synth_pkg::busReq_s                  busReq,
  output logic      [synth_pkg::DATA_W-1:0]        rdata,
  output synth_pkg::pump_s                         pump,
  output logic                                     calBusy,
  output logic                                     fastLockActive,
  output logic      [synth_pkg::VCO_SEL_W-1:0]     vcoCoreSelect
);

  localparam int DW = synth_pkg::DATA_W;
  localparam int CW = synth_pkg::CAL_CNT_W;
  localparam int FW = synth_pkg::FAST_CNT_W;
  localparam int VCO_HI = synth_pkg::VCO_SEL_LSB + synth_pkg::VCO_SEL_W - 1;

  // Elaboration checks: counter widths are fixed, so the counts must fit them
  if (FL_BASE < 1 || FL_STEP < 0 || FL_BASE + 15 * FL_STEP >= (1 << FW)) begin : gBadFast
    $error("fast-lock count does not fit the timer");
  end
  if (CL_MULT < 1 || CL_BASE < 0 || CL_TAIL < 1
      || CL_MULT * (CL_BASE + 32768) + CL_TAIL > (1 << CW)) begin : gBadCal
    $error("calibration timing parameters out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register port

  logic                 hit;
  logic [1:0]           idx;
  logic [4*DW-1:0]      words;
  logic [DW-1:0]        funcWord;
  logic [DW-1:0]        freq2Word;

  assign hit       = (busReq.addr >= synth_pkg::ADDR_FREQ1) && (busReq.addr <= synth_pkg::ADDR_FUNC);
  assign idx       = 2'(busReq.addr - synth_pkg::ADDR_FREQ1);
  assign funcWord  = words[3*DW +: DW];
  assign freq2Word = words[1*DW +: DW];

  reg_bank #(
    .W (DW),
    .N (synth_pkg::NUM_REGS)
  ) uBank (
    .mclk   (mclk),
    .rstn   (rstn),
    .wrEn   (busReq.wr && hit),
    .wrIdx  (idx),
    .wrData (busReq.wdata),
    .rdEn   (busReq.rd),
    .rdHit  (hit),
    .rdIdx  (idx),
    .rdData (rdata),
    .words  (words)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Field extraction

  logic                             fast_lock_enable;
  logic [synth_pkg::FAST_TMR_W-1:0] fastField;
  logic [synth_pkg::CAL_PREC_W-1:0] calPrecision;
  logic                             modeExt;
  logic [synth_pkg::PUMP_W-1:0]     normalPumpCurrent;
  logic [synth_pkg::PUMP_W-1:0]     boostPumpCurrent;

  assign fast_lock_enable            = funcWord[synth_pkg::FAST_EN_BIT];
  assign fastField         = funcWord[synth_pkg::FAST_TMR_LSB +: synth_pkg::FAST_TMR_W];
  assign calPrecision      = funcWord[synth_pkg::CAL_PREC_LSB +: synth_pkg::CAL_PREC_W];
  assign modeExt           = funcWord[synth_pkg::MODE_EXT_BIT];
  assign normalPumpCurrent = freq2Word[synth_pkg::PUMP_NORM_LSB +: synth_pkg::PUMP_W];
  assign boostPumpCurrent  = freq2Word[synth_pkg::PUMP_BOOST_LSB +: synth_pkg::PUMP_W];

  //////////////////////////////////////////////////////////////////////////////
  // Sequencer

  synth_pkg::seq_e state_r;
  synth_pkg::seq_e state_nxt;
  logic [CW-1:0]   calCnt_r;
  logic [FW-1:0]   fastCnt_r;
  logic [FW-1:0]   fastTerm_r;
  logic            fastArmed_r;
  logic            calStart;
  logic [CW-1:0]   calLoad;
  logic [FW-1:0]   fastTermCalc;
  logic            calDone;
  logic            fastDone;

  // Calibration only fires with the internal VCO path and the part powered
  assign calStart = busReq.wr && (busReq.addr == synth_pkg::ADDR_FREQ1) && !modeExt && powerDownN;

  // Cycle count minus one, since the count includes the final cycle
  assign calLoad = CW'(CL_MULT * (CL_BASE + (32'd1 << calPrecision)) + CL_TAIL - 1);

  // Terminal count from the timer field
  assign fastTermCalc = FW'(FL_BASE + FL_STEP * int'(fastField));

  assign calDone  = (calCnt_r == '0);
  assign fastDone = (fastCnt_r == fastTerm_r);

  // Next state; a fresh frequency write restarts calibration from any state
  always_comb begin
    state_nxt = state_r;
    if (!powerDownN) begin
      state_nxt = synth_pkg::ST_IDLE;
    end else if (calStart) begin
      state_nxt = synth_pkg::ST_CAL;
    end else begin
      unique case (state_r)
        synth_pkg::ST_IDLE: state_nxt = synth_pkg::ST_IDLE;
        synth_pkg::ST_CAL: begin
          if (calDone) begin
            state_nxt = fastArmed_r ? synth_pkg::ST_FAST : synth_pkg::ST_NORM;
          end
        end
        synth_pkg::ST_FAST: begin
          if (fastDone) begin
            state_nxt = synth_pkg::ST_NORM;
          end
        end
        synth_pkg::ST_NORM: state_nxt = synth_pkg::ST_NORM;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state_r <= synth_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Enable and terminal count are caught at the write so later edits cannot cut a run short
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fastArmed_r <= 1'b0;
      fastTerm_r  <= '0;
    end else if (calStart) begin
      fastArmed_r <= fast_lock_enable;
      fastTerm_r  <= fastTermCalc;
    end
  end

  // Calibration down-counter
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      calCnt_r <= '0;
    end else if (calStart) begin
      calCnt_r <= calLoad;
    end else if (state_r == synth_pkg::ST_CAL && !calDone) begin
      calCnt_r <= calCnt_r - CW'(1);
    end
  end

  // Fast-lock timer: first FAST cycle is count 1, so the phase lasts the terminal count
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fastCnt_r <= '0;
    end else if (state_nxt == synth_pkg::ST_FAST && state_r != synth_pkg::ST_FAST) begin
      fastCnt_r <= FW'(1);
    end else if (state_r == synth_pkg::ST_FAST) begin
      fastCnt_r <= fastCnt_r + FW'(1);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registered outputs, aligned with state_r

  // Pump off and tuning on reference while calibrating; boost current in fast-lock
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pump <= '0;
    end else begin
      pump.enable    <= powerDownN && (state_nxt != synth_pkg::ST_CAL);
      pump.tuneToRef <= (state_nxt == synth_pkg::ST_CAL);
      pump.current   <= (state_nxt == synth_pkg::ST_FAST) ? boostPumpCurrent
                                                           : normalPumpCurrent;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      calBusy        <= 1'b0;
      fastLockActive <= 1'b0;
    end else begin
      calBusy        <= (state_nxt == synth_pkg::ST_CAL);
      fastLockActive <= (state_nxt == synth_pkg::ST_FAST);
    end
  end

  // Core select taken from the frequency word; band search follows in calibration
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      vcoCoreSelect <= '0;
    end else if (calStart) begin
      vcoCoreSelect <= busReq.wdata[synth_pkg::VCO_SEL_LSB +: synth_pkg::VCO_SEL_W];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [CW-1:0]                    calSeen_r;
  logic [FW-1:0]                    fastSeen_r;
  logic [synth_pkg::CAL_PREC_W-1:0] calPrecAt_r;

  // Precision as it stood at the write, so later edits cannot blur the check
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      calPrecAt_r <= '0;
    end else if (calStart) begin
      calPrecAt_r <= calPrecision;
    end
  end

  // Independent cycle counters for the phase-length checks
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      calSeen_r  <= '0;
      fastSeen_r <= '0;
    end else begin
      calSeen_r  <= (state_r == synth_pkg::ST_CAL && !calStart) ? calSeen_r + CW'(1) : '0;
      fastSeen_r <= (state_r == synth_pkg::ST_FAST && !calStart) ? fastSeen_r + FW'(1) : '0;
    end
  end

  a_cal_start: assert property (@(posedge mclk) disable iff (!rstn)
    calStart |=> calBusy && state_r == synth_pkg::ST_CAL)
    else $error("calibration did not start on frequency write");

  a_cal_blocked: assert property (@(posedge mclk) disable iff (!rstn)
    (busReq.wr && busReq.addr == synth_pkg::ADDR_FREQ1 && (modeExt || !powerDownN)
     && state_r != synth_pkg::ST_CAL) |=> !calBusy)
    else $error("calibration started while blocked");

  a_cal_isolate: assert property (@(posedge mclk) disable iff (!rstn)
    calBusy |-> !pump.enable && pump.tuneToRef)
    else $error("pump active during calibration");

  a_cal_length: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == synth_pkg::ST_CAL && state_nxt != synth_pkg::ST_CAL && powerDownN && !calStart)
    |-> int'(calSeen_r) + 1 == (CL_BASE + (1 << calPrecAt_r)) * CL_MULT + CL_TAIL)
    else $error("calibration length wrong");

  a_fast_entry: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == synth_pkg::ST_CAL && calDone && fastArmed_r && powerDownN && !calStart)
    |=> fastLockActive ##1 fastLockActive)
    else $error("fast-lock not entered after calibration");

  a_fast_current: assert property (@(posedge mclk) disable iff (!rstn)
    (fastLockActive && $stable(freq2Word)) |-> pump.current == boostPumpCurrent && pump.enable)
    else $error("boost current missing in fast-lock");

  a_fast_length: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == synth_pkg::ST_FAST && !calStart && powerDownN && fastDone)
    |-> int'(fastSeen_r) + 1 == int'(fastTerm_r))
    else $error("fast-lock length differs from terminal count");

  a_fast_exit: assert property (@(posedge mclk) disable iff (!rstn)
    (state_r == synth_pkg::ST_FAST && fastDone && !calStart && powerDownN)
    |=> !fastLockActive && pump.current == $past(normalPumpCurrent))
    else $error("normal current not restored after fast-lock");

  a_vco_select: assert property (@(posedge mclk) disable iff (!rstn)
    calStart |=> vcoCoreSelect == $past(busReq.wdata[VCO_HI:synth_pkg::VCO_SEL_LSB]))
    else $error("core select not taken from frequency word");

endmodule
`default_nettype wire

/* File: bench/host_model.sv */
// Host controller model driving the register port and the power pin
`timescale 1ns/1ps
`default_nettype none
module host_model #(
  parameter int BIAS_CYC = 40,
  parameter int RAMP_CYC = 80
) (
  input  wire logic               mclk,
  output var  synth_pkg::busReq_s busReq,
  output var  logic               powerDownN
);
  // Idle bus at time zero, pin held low while supplies ramp
  initial begin
    busReq = '0;
    powerDownN = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // One access; released lines show the inverse so stale values never look valid
  task automatic access(input logic wr, input logic [2:0] a, input logic [19:0] d);
    @(posedge mclk);
    busReq <= '{wr: wr, rd: ~wr, addr: a, wdata: d};
    @(posedge mclk);
    busReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  // Regulator settle before any register write, shortened to keep runs small
  task automatic ramp();
    repeat (RAMP_CYC) @(posedge mclk);
  endtask
  // Bias settle after the pin rises, before the locking frequency write
  task automatic powerOn();
    @(posedge mclk);
    powerDownN <= 1'b1;
    repeat (BIAS_CYC) @(posedge mclk);
  endtask
  task automatic powerOff();
    @(posedge mclk);
    powerDownN <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: bench/synth_fastlock_vco_cal_sequencer_test.sv */
// Self-checking bench for the calibration and fast-lock sequencer
`timescale 1ns/1ps
`default_nettype none
module synth_fastlock_vco_cal_sequencer_test;
  // Documented counts; every expectation follows these
  localparam int FLB = synth_pkg::FAST_BASE;
  localparam int FLS = synth_pkg::FAST_STEP;
  localparam int CLB = synth_pkg::CAL_BASE;
  localparam int CLM = synth_pkg::CAL_MULT;
  localparam int CLT = synth_pkg::CAL_TAIL;
  logic               mclk;
  logic               rstn;
  logic               powerDownN;
  synth_pkg::busReq_s busReq;
  logic [19:0]        rdata;
  synth_pkg::pump_s   pump;
  logic               calBusy;
  logic               fastLockActive;
  logic [1:0]         vcoCoreSelect;
  int                 n_mismatch = 0;
  int                 tests_run = 0;
  int                 seed = 90;
  int                 calCnt = 0;
  int                 fastCnt = 0;
  logic               rdPend = 1'b0;
  logic [19:0]        expRd[$];
  int                 expCal[$];
  int                 expFast[$];
  logic [2:0]         expNorm;
  logic [2:0]         expBoost;
  logic [1:0]         expVco;
  //////////////////////////////////////////////////////////////////////////////
  host_model #(.BIAS_CYC(40), .RAMP_CYC(80)) u_host (.mclk(mclk), .busReq(busReq), .powerDownN(powerDownN));
  synth_fastlock_vco_cal_sequencer #(
    .FL_BASE(FLB), .FL_STEP(FLS), .CL_BASE(CLB), .CL_MULT(CLM), .CL_TAIL(CLT)
  ) u_dut (
    .mclk(mclk), .rstn(rstn), .powerDownN(powerDownN), .busReq(busReq), .rdata(rdata),
    .pump(pump), .calBusy(calBusy), .fastLockActive(fastLockActive), .vcoCoreSelect(vcoCoreSelect)
  );
  // Free-running clock at 125 MHz
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Watchdog, generous against the few thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    $display("Watchdog ran out");
    report_and_stop();
  end
  //////////////////////////////////////////////////////////////////////////////
  // Monitor: sampled at the edge, so it sees the settled values of the last cycle
  always @(posedge mclk) begin
    if (rdPend) check(rdata, expRd.pop_front());
    rdPend = busReq.rd;
    if (calBusy === 1'b1) begin
      calCnt++;
      check({pump.tuneToRef, pump.enable}, 2'b10);
    end else if (calCnt > 0) begin
      // An unlooked-for calibration meets an empty queue and fails
      check(calCnt, expCal.size() > 0 ? expCal.pop_front() : 0);
      check(vcoCoreSelect, expVco);
      check(pump.current, fastLockActive === 1'b1 ? expBoost : expNorm);
      calCnt = 0;
    end
    if (fastLockActive === 1'b1) begin
      fastCnt++;
      check({pump.enable, pump.current}, {1'b1, expBoost});
    end else if (fastCnt > 0) begin
      check(fastCnt, expFast.size() > 0 ? expFast.pop_front() : 0);
      check({pump.enable, pump.current}, {1'b1, expNorm});
      fastCnt = 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // One calibration, optionally restarted five cycles into it
  task automatic runCal(input logic fe, input logic [3:0] f, input logic [3:0] p, input logic m0, input logic rs);
    logic [19:0] r;
    r = $random(seed);
    expNorm = r[2:0];
    expBoost = r[5:3];
    expVco = {r[7] & ~r[6], r[6]};
    u_host.access(1'b1, synth_pkg::ADDR_FUNC, {p, 4'h0, fe, f, 3'h0, 1'b0, m0, 2'h0});
    u_host.access(1'b1, synth_pkg::ADDR_FREQ2, {1'b0, expNorm, 1'b0, expBoost, r[19:8]});
    expCal.push_back((CLB + 2 ** p) * CLM + CLT + (rs ? 5 : 0));
    if (fe) expFast.push_back(FLB + FLS * f);
    u_host.access(1'b1, synth_pkg::ADDR_FREQ1, {2'b00, expVco, r[15:0]});
    if (rs) begin
      repeat (3) @(posedge mclk);
      u_host.access(1'b1, synth_pkg::ADDR_FREQ1, {2'b00, expVco, r[19:4]});
    end
    repeat (2) @(posedge mclk);
    for (int i = 0; i < 2500 && (calBusy !== 1'b0 || fastLockActive !== 1'b0); i++) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  // Main sequence
  initial begin
    logic [19:0] w[4];
    logic [19:0] r;
    rstn = 1'b0;
    repeat (3) @(posedge mclk);
    rstn <= 1'b1;
    // Registers written and read back while powered down
    u_host.ramp();
    for (int a = 1; a <= 4; a++) begin
      w[a-1] = $random(seed);
      u_host.access(1'b1, 3'(a), w[a-1]);
    end
    for (int a = 0; a < 8; a++) begin
      expRd.push_back((a >= 1 && a <= 4) ? w[(a - 1) & 3] : 20'h00000);
      u_host.access(1'b0, 3'(a), 20'h00000);
    end
    repeat (2) @(posedge mclk);
    check(calBusy, 1'b0);
    $display("Test registers done");
    // Calibrations with and without fast-lock, low precision keeps runs short
    u_host.powerOn();
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      runCal(i != 1, {2'b00, r[1:0]}, {2'b00, r[3:2] == 2'b00 ? 2'b01 : r[3:2]}, i[0], i == 3);
    end
    $display("Test calibration done");
    // Modes with bit 1 set, then power down: writes stored, no calibration
    for (int m = 2; m < 4; m++) begin
      u_host.access(1'b1, synth_pkg::ADDR_FUNC, {4'h1, 4'h0, 1'b1, 4'h0, 3'h0, 2'(m), 2'h0});
      u_host.access(1'b1, synth_pkg::ADDR_FREQ1, 20'h12345);
      repeat (20) @(posedge mclk);
      check({calBusy, pump.enable, pump.current}, {2'b01, expNorm});
    end
    u_host.powerOff();
    repeat (2) @(posedge mclk);
    u_host.access(1'b1, synth_pkg::ADDR_FUNC, {4'h1, 4'h0, 1'b1, 4'h0, 4'h0, 3'h0});
    u_host.access(1'b1, synth_pkg::ADDR_FREQ1, 20'h0ABCD);
    repeat (20) @(posedge mclk);
    check({calBusy, fastLockActive, pump.enable}, 3'b000);
    check(expCal.size() + expFast.size(), 0);
    $display("Test refusals done");
    report_and_stop();
  end
endmodule
`default_nettype wire
